// file: eag_pkg.sv
// Package of types and constants shared by the effective address generator files.
package eag_pkg;

    localparam int          EAG_AW         = 16;
    localparam int          EAG_DW         = 8;
    localparam logic [7:0]  EAG_PAGE_ZERO  = 8'h00;
    localparam logic [7:0]  EAG_PTR_LO_END = 8'hFF;
    localparam logic [1:0]  EAG_LEN_ONE    = 2'h1;
    localparam logic [1:0]  EAG_LEN_TWO    = 2'h2;
    localparam logic [1:0]  EAG_LEN_THREE  = 2'h3;
    localparam logic [1:0]  EAG_XTRA_ONE   = 2'h1;
    localparam logic [1:0]  EAG_XTRA_TWO   = 2'h2;
    localparam logic [15:0] EAG_ONE16      = 16'h0001;

    // The fifteen operand addressing modes.
    typedef enum logic [3:0] {
        EAG_M_IMPLIED,
        EAG_M_ACCUM,
        EAG_M_IMMEDIATE,
        EAG_M_ABSOLUTE,
        EAG_M_PAGE_ZERO,
        EAG_M_PAGE_ZERO_X,
        EAG_M_PAGE_ZERO_Y,
        EAG_M_ABSOLUTE_X,
        EAG_M_ABSOLUTE_Y,
        EAG_M_ABS_X_POINTER,
        EAG_M_RELATIVE,
        EAG_M_PRE_X_POINTER,
        EAG_M_POST_Y_POINTER,
        EAG_M_ABS_POINTER,
        EAG_M_PAGE_ZERO_POINTER
    } eag_mode_e;

    // Sequencer states.
    typedef enum logic [2:0] {
        EAG_S_IDLE,
        EAG_S_FETCH1,
        EAG_S_FETCH2,
        EAG_S_PTR_LO,
        EAG_S_PTR_HI,
        EAG_S_EXTRA,
        EAG_S_FINISH
    } eag_state_e;

    // Result of opcode decoding.
    typedef struct packed {
        eag_mode_e mode;
        logic      store_op;
        logic      arith_op;
        logic      bit_test_imm;
        logic      jump_op;
    } eag_dec_s;

    // Request from the instruction register and register file.
    typedef struct packed {
        logic [7:0]  opcode;
        logic [15:0] pc;
        logic [7:0]  idx_x;
        logic [7:0]  idx_y;
        logic        decimal;
        logic        branch_taken;
    } eag_req_s;

endpackage

// file: eag_opcode_decoder.sv
// Opcode to addressing mode and instruction class decoder.
`timescale 1ns/10ps
module eag_opcode_decoder
    import eag_pkg::*;
(
    // Opcode in.
    input  wire logic [7:0] opcode,
    // Decoded mode and class.
    output eag_dec_s        dec
);

    logic [2:0] grp_a;
    logic [2:0] grp_b;
    logic [1:0] grp_c;

    assign grp_a = opcode[7:5];
    assign grp_b = opcode[4:2];
    assign grp_c = opcode[1:0];

    // Map every opcode onto exactly one of the fifteen modes.
    always_comb begin
        dec.mode         = EAG_M_IMPLIED;
        dec.store_op     = 1'b0;
        dec.arith_op     = 1'b0;
        dec.bit_test_imm = (opcode == 8'h89);
        dec.jump_op      = (opcode == 8'h6C) || (opcode == 8'h7C);
        case (grp_c)
            2'h1: begin
                dec.store_op = (grp_a == 3'h4) && (opcode != 8'h89);
                dec.arith_op = (grp_a == 3'h3) || (grp_a == 3'h7);
                case (grp_b)
                    3'h0:    dec.mode = EAG_M_PRE_X_POINTER;
                    3'h1:    dec.mode = EAG_M_PAGE_ZERO;
                    3'h2:    dec.mode = EAG_M_IMMEDIATE;
                    3'h3:    dec.mode = EAG_M_ABSOLUTE;
                    3'h4:    dec.mode = EAG_M_POST_Y_POINTER;
                    3'h5:    dec.mode = EAG_M_PAGE_ZERO_X;
                    3'h6:    dec.mode = EAG_M_ABSOLUTE_Y;
                    default: dec.mode = EAG_M_ABSOLUTE_X;
                endcase
            end
            2'h2: begin
                dec.store_op = (opcode == 8'h9E);
                case (grp_b)
                    3'h0:    dec.mode = EAG_M_IMMEDIATE;
                    3'h1:    dec.mode = EAG_M_PAGE_ZERO;
                    3'h2:    dec.mode = grp_a[2] ? EAG_M_IMPLIED : EAG_M_ACCUM;
                    3'h3:    dec.mode = EAG_M_ABSOLUTE;
                    3'h4:    dec.mode = EAG_M_PAGE_ZERO_POINTER;
                    3'h5:    dec.mode = (grp_a[2:1] == 2'h2) ? EAG_M_PAGE_ZERO_Y
                                                               : EAG_M_PAGE_ZERO_X;
                    3'h6:    dec.mode = (grp_a[2:1] == 2'h0) ? EAG_M_ACCUM : EAG_M_IMPLIED;
                    default: dec.mode = (grp_a == 3'h5) ? EAG_M_ABSOLUTE_Y : EAG_M_ABSOLUTE_X;
                endcase
            end
            2'h0: begin
                dec.store_op = (opcode == 8'h64) || (opcode == 8'h74)
                            || (opcode == 8'h9C);
                case (grp_b)
                    3'h0: begin
                        if (opcode == 8'h80) begin
                            dec.mode = EAG_M_RELATIVE;
                        end else if (opcode == 8'h20) begin
                            dec.mode = EAG_M_ABSOLUTE;
                        end else if (grp_a[2]) begin
                            dec.mode = EAG_M_IMMEDIATE;
                        end else begin
                            dec.mode = EAG_M_IMPLIED;
                        end
                    end
                    3'h1:    dec.mode = EAG_M_PAGE_ZERO;
                    3'h3: begin
                        if (opcode == 8'h6C) begin
                            dec.mode = EAG_M_ABS_POINTER;
                        end else begin
                            dec.mode = EAG_M_ABSOLUTE;
                        end
                    end
                    3'h4:    dec.mode = EAG_M_RELATIVE;
                    3'h5:    dec.mode = EAG_M_PAGE_ZERO_X;
                    3'h7: begin
                        if (opcode == 8'h7C) begin
                            dec.mode = EAG_M_ABS_X_POINTER;
                        end else begin
                            dec.mode = (opcode == 8'h9C) ? EAG_M_ABSOLUTE : EAG_M_ABSOLUTE_X;
                        end
                    end
                    default: dec.mode = EAG_M_IMPLIED;
                endcase
            end
            default: dec.mode = EAG_M_IMPLIED;
        endcase
    end

endmodule // eag_opcode_decoder

// file: eag_index_adder.sv
// Sixteen bit base plus eight bit index or signed offset, with page crossing flag.
`timescale 1ns/10ps
module eag_index_adder
    import eag_pkg::*;
(
    // Operands.
    input  wire logic [15:0] base,
    input  wire logic [7:0]  offset,
    input  wire logic        signed_off,
    // Result.
    output logic [15:0]      sum,
    output logic             page_cross
);

    logic [15:0] ext_off;

    // The sum wraps within the address space; the page changes when the high byte does.
    always_comb begin
        ext_off    = {(signed_off && offset[7]) ? 8'hFF : 8'h00, offset};
        sum        = base + ext_off;
        page_cross = (sum[15:8] != base[15:8]);
    end

endmodule // eag_index_adder

// file: eag_effective_address.sv
// Effective address sequencer for all operand addressing modes.
`timescale 1ns/10ps

module eag_effective_address
    import eag_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Request from decode.
    input  wire logic        start,
    input  eag_req_s         req,
    // Memory read port.
    output logic [15:0]      mem_addr,
    output logic             mem_rd,
    input  wire logic [7:0]  mem_rdata,
    // Results.
    output logic             busy,
    output logic             done,
    output eag_mode_e        mode,
    output logic [15:0]      eff_addr,
    output logic [7:0]       operand,
    output logic [15:0]      pc_next,
    output logic             pc_load,
    output logic             acc_target,
    output logic             keep_nv
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        eag_state_e  st;
        eag_dec_s    dec;
        eag_req_s    req;
        logic [7:0]  b1;
        logic [15:0] ptr;
        logic [7:0]  lo;
        logic [15:0] ea;
        logic [7:0]  operand;
        logic [1:0]  extra;
    } eag_core_s;

    eag_core_s   core_q;
    eag_core_s   core_d;
    eag_dec_s    dec_new;
    logic [15:0] add_base;
    logic [7:0]  add_off;
    logic        add_sgn;
    logic [15:0] add_sum;
    logic        add_cross;
    logic [1:0]  xtra;

    // Instruction length in bytes for each mode.
    function automatic logic [1:0] eag_len(input eag_mode_e m);
        case (m)
            EAG_M_IMPLIED, EAG_M_ACCUM:                          eag_len = EAG_LEN_ONE;
            EAG_M_ABSOLUTE, EAG_M_ABSOLUTE_X, EAG_M_ABSOLUTE_Y,
            EAG_M_ABS_POINTER, EAG_M_ABS_X_POINTER:              eag_len = EAG_LEN_THREE;
            default:                                             eag_len = EAG_LEN_TWO;
        endcase
    endfunction

    // Pointer modes that live in page zero.
    function automatic logic eag_zp_ptr(input eag_mode_e m);
        eag_zp_ptr = (m == EAG_M_PRE_X_POINTER) || (m == EAG_M_POST_Y_POINTER)
                  || (m == EAG_M_PAGE_ZERO_POINTER);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    eag_opcode_decoder u_dec (
        .opcode (req.opcode),
        .dec    (dec_new)
    );

    eag_index_adder u_add (
        .base       (add_base),
        .offset     (add_off),
        .signed_off (add_sgn),
        .sum        (add_sum),
        .page_cross (add_cross)
    );

    // Adder operand selection by state and mode.
    always_comb begin
        add_base = {mem_rdata, core_q.b1};
        add_off  = core_q.req.idx_x;
        add_sgn  = 1'b0;
        case (core_q.st)
            EAG_S_FETCH1: begin
                add_base = core_q.req.pc + {14'h0000, EAG_LEN_TWO};
                add_off  = mem_rdata;
                add_sgn  = 1'b1;
            end
            EAG_S_FETCH2: begin
                add_off = (core_q.dec.mode == EAG_M_ABSOLUTE_Y) ? core_q.req.idx_y
                                                                : core_q.req.idx_x;
            end
            EAG_S_PTR_HI: begin
                add_base = {mem_rdata, core_q.lo};
                add_off  = core_q.req.idx_y;
            end
            default: add_base = {mem_rdata, core_q.b1};
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer.

    // Next state of the whole core.
    always_comb begin
        core_d = core_q;
        xtra   = core_q.extra;
        case (core_q.st)
            EAG_S_IDLE: begin
                if (start) begin
                    core_d.dec   = dec_new;
                    core_d.req   = req;
                    core_d.ea    = 16'h0000;
                    core_d.extra = (dec_new.arith_op && req.decimal) ? EAG_XTRA_ONE
                                                                     : 2'h0;
                    if (dec_new.mode == EAG_M_IMPLIED || dec_new.mode == EAG_M_ACCUM) begin
                        core_d.st = EAG_S_FINISH;
                    end else begin
                        core_d.st = EAG_S_FETCH1;
                    end
                end
            end
            EAG_S_FETCH1: begin
                core_d.b1 = mem_rdata;
                core_d.st = EAG_S_FINISH;
                case (core_q.dec.mode)
                    EAG_M_IMMEDIATE: core_d.operand = mem_rdata;
                    EAG_M_PAGE_ZERO: core_d.ea = {EAG_PAGE_ZERO, mem_rdata};
                    EAG_M_PAGE_ZERO_X: begin
                        core_d.ea = {EAG_PAGE_ZERO, mem_rdata + core_q.req.idx_x};
                    end
                    EAG_M_PAGE_ZERO_Y: begin
                        core_d.ea = {EAG_PAGE_ZERO, mem_rdata + core_q.req.idx_y};
                    end
                    EAG_M_RELATIVE: begin
                        core_d.ea = add_sum;
                        if (core_q.req.branch_taken) begin
                            xtra = add_cross ? EAG_XTRA_TWO : EAG_XTRA_ONE;
                        end
                    end
                    EAG_M_PRE_X_POINTER: begin
                        core_d.ptr = {EAG_PAGE_ZERO, mem_rdata + core_q.req.idx_x};
                        core_d.st  = EAG_S_PTR_LO;
                    end
                    EAG_M_POST_Y_POINTER, EAG_M_PAGE_ZERO_POINTER: begin
                        core_d.ptr = {EAG_PAGE_ZERO, mem_rdata};
                        core_d.st  = EAG_S_PTR_LO;
                    end
                    default: core_d.st = EAG_S_FETCH2;
                endcase
            end
            EAG_S_FETCH2: begin
                core_d.st = EAG_S_FINISH;
                case (core_q.dec.mode)
                    EAG_M_ABSOLUTE_X, EAG_M_ABSOLUTE_Y: begin
                        core_d.ea = add_sum;
                        if (add_cross && !core_q.dec.store_op) begin
                            xtra = core_q.extra + EAG_XTRA_ONE;
                        end
                    end
                    EAG_M_ABS_POINTER: begin
                        core_d.ptr = {mem_rdata, core_q.b1};
                        core_d.st  = EAG_S_PTR_LO;
                        if (core_q.b1 == EAG_PTR_LO_END) begin
                            xtra = core_q.extra + EAG_XTRA_ONE;
                        end
                    end
                    EAG_M_ABS_X_POINTER: begin
                        core_d.ptr = add_sum;
                        core_d.st  = EAG_S_PTR_LO;
                    end
                    default: core_d.ea = {mem_rdata, core_q.b1};
                endcase
            end
            EAG_S_PTR_LO: begin
                core_d.lo = mem_rdata;
                core_d.st = EAG_S_PTR_HI;
            end
            EAG_S_PTR_HI: begin
                core_d.st = EAG_S_FINISH;
                if (core_q.dec.mode == EAG_M_POST_Y_POINTER) begin
                    core_d.ea = add_sum;
                    if (add_cross && !core_q.dec.store_op) begin
                        xtra = core_q.extra + EAG_XTRA_ONE;
                    end
                end else begin
                    core_d.ea = {mem_rdata, core_q.lo};
                end
            end
            EAG_S_EXTRA: begin
                xtra      = core_q.extra - EAG_XTRA_ONE;
                core_d.st = (core_q.extra == EAG_XTRA_ONE) ? EAG_S_FINISH : EAG_S_EXTRA;
            end
            EAG_S_FINISH: core_d.st = EAG_S_IDLE;
            default:      core_d.st = EAG_S_IDLE;
        endcase
        // Any owed cycles are spent before the result is handed over.
        if (core_q.st != EAG_S_IDLE) begin
            core_d.extra = xtra;
        end
        if (core_d.st == EAG_S_FINISH && core_q.st != EAG_S_EXTRA && core_d.extra != 2'h0) begin
            core_d.st = EAG_S_EXTRA;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            core_q <= '0;
        end else begin
            core_q <= core_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Memory port and results.

    // Read address for the byte wanted in the current state.
    always_comb begin
        mem_rd   = 1'b1;
        mem_addr = core_q.req.pc;
        case (core_q.st)
            EAG_S_FETCH1: mem_addr = core_q.req.pc + EAG_ONE16;
            EAG_S_FETCH2: mem_addr = core_q.req.pc + {14'h0000, EAG_LEN_TWO};
            EAG_S_PTR_LO: mem_addr = core_q.ptr;
            EAG_S_PTR_HI: begin
                if (eag_zp_ptr(core_q.dec.mode)) begin
                    mem_addr = {EAG_PAGE_ZERO, core_q.ptr[7:0] + 8'h01};
                end else begin
                    mem_addr = core_q.ptr + EAG_ONE16;
                end
            end
            EAG_S_EXTRA: begin
                mem_addr = core_q.req.pc + {14'h0000, eag_len(core_q.dec.mode)}
                         - EAG_ONE16;
            end
            default: begin
                mem_rd   = 1'b0;
                mem_addr = core_q.req.pc;
            end
        endcase
    end

    // Results other than busy and done held from the finishing cycle until the next request.
    assign busy       = (core_q.st != EAG_S_IDLE);
    assign done       = (core_q.st == EAG_S_FINISH);
    assign mode       = core_q.dec.mode;
    assign eff_addr   = core_q.ea;
    assign operand    = core_q.operand;
    assign pc_load    = core_q.dec.jump_op;
    assign acc_target = (core_q.dec.mode == EAG_M_ACCUM);
    assign keep_nv    = core_q.dec.bit_test_imm;

    // Next program counter: jump target, taken branch target, or the following instruction.
    always_comb begin
        if (core_q.dec.jump_op) begin
            pc_next = core_q.ea;
        end else if (core_q.dec.mode == EAG_M_RELATIVE && core_q.req.branch_taken) begin
            pc_next = core_q.ea;
        end else begin
            pc_next = core_q.req.pc + {14'h0000, eag_len(core_q.dec.mode)};
        end
    end

endmodule // eag_effective_address

// file: eag_memory_model.sv
// Byte-wide memory model that answers the generator's read port.
`timescale 1ns/10ps
module eag_memory_model (
    // Clock.
    input  wire logic        clk,
    // Read port.
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    output logic [7:0]       mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;

    // Remembers the last byte served so an idle bus can show its inverse.
    always @(posedge clk) begin
        if (mem_rd) last_q <= mem[mem_addr];
    end

    // An unread bus never repeats the old byte, so stale data cannot pass for a fresh read.
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
endmodule // eag_memory_model

// file: eag_effective_address_checker.sv
// Concurrent checks on the ports of the effective address sequencer.
`timescale 1ns/10ps
module eag_effective_address_checker
    import eag_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Request.
    input  wire logic        start,
    input  eag_req_s         req,
    // Memory port.
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    // Results.
    input  wire logic        busy,
    input  wire logic        done,
    input  eag_mode_e        mode,
    input  wire logic [15:0] eff_addr,
    input  wire logic [15:0] pc_next,
    input  wire logic        pc_load,
    input  wire logic        acc_target,
    input  wire logic        keep_nv
);
    logic [15:0] pc_q;

    // Holds the opcode address of the request in flight.
    always_ff @(posedge clk) begin
        if (!rst_b) pc_q <= 16'h0000;
        else if (start && !busy) pc_q <= req.pc;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////////
    first_read_a: assert property (
        (start && !busy) |=> (done || (mem_rd && mem_addr == pc_q + 16'h0001)))
        else $error("first read is not the byte after the opcode");
    no_read_a: assert property (
        (busy && !$past(busy) && mode inside {EAG_M_IMPLIED, EAG_M_ACCUM}) |-> (done && !mem_rd))
        else $error("implied or accumulator request read memory");
    zp_page_a: assert property (
        (done && mode inside {EAG_M_PAGE_ZERO, EAG_M_PAGE_ZERO_X, EAG_M_PAGE_ZERO_Y})
        |-> eff_addr[15:8] == EAG_PAGE_ZERO) else $error("page zero address left page zero");
    zp_ptr_a: assert property (
        (busy && mem_rd && mode inside {EAG_M_PRE_X_POINTER, EAG_M_POST_Y_POINTER,
        EAG_M_PAGE_ZERO_POINTER}) |-> (mem_addr == pc_q + 16'h0001 || mem_addr[15:8] == 8'h00))
        else $error("page zero pointer read outside page zero");
    extra_last_a: assert property (
        (busy && mem_rd && mode inside {EAG_M_ABSOLUTE_X, EAG_M_ABSOLUTE_Y})
        |-> (mem_addr == pc_q + 16'h0001 || mem_addr == pc_q + 16'h0002))
        else $error("indexed read outside the instruction bytes");
    latency_a: assert property ((start && !busy) |-> ##[1:6] done)
        else $error("request did not finish in six cycles");
    jump_load_a: assert property (
        done |-> (pc_load == (mode inside {EAG_M_ABS_X_POINTER, EAG_M_ABS_POINTER}))
        && (!pc_load || pc_next == eff_addr)) else $error("jump target not loaded");
    acc_flag_a: assert property (done |-> acc_target == (mode == EAG_M_ACCUM)
        && (!acc_target || pc_next == pc_q + 16'h0001)) else $error("accumulator flag wrong");
    bit_imm_a: assert property ((done && keep_nv) |-> mode == EAG_M_IMMEDIATE)
        else $error("flag keep outside immediate mode");
endmodule // eag_effective_address_checker

bind eag_effective_address eag_effective_address_checker chk_i (.clk(clk), .rst_b(rst_b),
    .start(start), .req(req), .mem_addr(mem_addr), .mem_rd(mem_rd), .busy(busy), .done(done),
    .mode(mode), .eff_addr(eff_addr), .pc_next(pc_next), .pc_load(pc_load),
    .acc_target(acc_target), .keep_nv(keep_nv));

// file: effective_address_generator_bench.sv
// Self-checking bench for the effective address sequencer.
`timescale 1ns/10ps
module effective_address_generator_bench
    import eag_pkg::*;
();
    typedef struct {
        int          cyc;
        logic [2:0]  lat;
        eag_mode_e   md;
        logic [15:0] ea;
        logic        ea_on;
        logic [15:0] pcn;
        logic [7:0]  opd;
        logic        opd_on;
        logic [2:0]  flg;
    } eag_note_s;
    localparam logic [7:0] OPS [22] = '{8'hE8, 8'h0A, 8'hA9, 8'h89, 8'h69, 8'hAD, 8'hA5,
        8'hB5, 8'hB6, 8'hBD, 8'h9D, 8'h7D, 8'hB9, 8'h7C, 8'hD0, 8'hA1, 8'hB1, 8'h91, 8'hF1,
        8'h6C, 8'hB2, 8'h9E};
    localparam eag_mode_e MDS [22] = '{EAG_M_IMPLIED, EAG_M_ACCUM, EAG_M_IMMEDIATE,
        EAG_M_IMMEDIATE, EAG_M_IMMEDIATE, EAG_M_ABSOLUTE, EAG_M_PAGE_ZERO, EAG_M_PAGE_ZERO_X,
        EAG_M_PAGE_ZERO_Y, EAG_M_ABSOLUTE_X, EAG_M_ABSOLUTE_X, EAG_M_ABSOLUTE_X,
        EAG_M_ABSOLUTE_Y, EAG_M_ABS_X_POINTER, EAG_M_RELATIVE, EAG_M_PRE_X_POINTER,
        EAG_M_POST_Y_POINTER, EAG_M_POST_Y_POINTER, EAG_M_POST_Y_POINTER, EAG_M_ABS_POINTER,
        EAG_M_PAGE_ZERO_POINTER, EAG_M_ABSOLUTE_X};

    logic        clk, rst_b, start, mem_rd, busy, done, pc_load, acc_target, keep_nv;
    eag_req_s    req;
    eag_mode_e   mode;
    logic [15:0] mem_addr, eff_addr, pc_next;
    logic [7:0]  mem_rdata, operand;
    logic [31:0] seed = 32'h00000037;
    int          cyc = 0;
    int          miscompares = 0;
    int          n_checks = 0;
    eag_note_s   notes [$];
    eag_note_s   mn;

    eag_effective_address uut (.clk(clk), .rst_b(rst_b), .start(start), .req(req),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .busy(busy), .done(done),
        .mode(mode), .eff_addr(eff_addr), .operand(operand), .pc_next(pc_next),
        .pc_load(pc_load), .acc_target(acc_target), .keep_nv(keep_nv));
    eag_memory_model mem_i (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] m(input logic [15:0] a);
        return mem_i.mem[a];
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        miscompares += notes.size();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Works out one request's expected outcome, notes it and issues it.
    task automatic run(input logic [7:0] op, input eag_mode_e md, input logic frc);
        logic [31:0] r, s;
        logic [15:0] pc, base, ea, nx;
        logic [7:0]  x, y, b1;
        logic [2:0]  rd, ex;
        logic        st;
        eag_note_s   n;
        int          w;
        r = rnd();
        s = rnd();
        pc = r[15:0];
        x = r[23:16];
        y = r[31:24];
        if (frc) mem_i.mem[pc + 16'h0001] = 8'hFF;
        b1 = m(pc + 16'h0001);
        base = {m(pc + 16'h0002), b1};
        st = (op == 8'h9D) || (op == 8'h91) || (op == 8'h9E);
        case (md)
            EAG_M_ABSOLUTE: ea = base;
            EAG_M_PAGE_ZERO: ea = {8'h00, b1};
            EAG_M_PAGE_ZERO_X: ea = {8'h00, b1 + x};
            EAG_M_PAGE_ZERO_Y: ea = {8'h00, b1 + y};
            EAG_M_ABSOLUTE_X: ea = base + x;
            EAG_M_ABSOLUTE_Y: ea = base + y;
            EAG_M_ABS_X_POINTER: ea = {m(base + x + 16'h0001), m(base + x)};
            EAG_M_RELATIVE: ea = pc + 16'h0002 + {{8{b1[7]}}, b1};
            EAG_M_PRE_X_POINTER: ea = {m({8'h00, b1 + x + 8'h01}), m({8'h00, b1 + x})};
            EAG_M_POST_Y_POINTER: ea = {m({8'h00, b1 + 8'h01}), m({8'h00, b1})} + y;
            EAG_M_ABS_POINTER: ea = {m(base + 16'h0001), m(base)};
            default: ea = {m({8'h00, b1 + 8'h01}), m({8'h00, b1})};
        endcase
        rd = 3'h2;
        if (md inside {EAG_M_IMPLIED, EAG_M_ACCUM}) rd = 3'h0;
        if (md inside {EAG_M_IMMEDIATE, EAG_M_PAGE_ZERO, EAG_M_PAGE_ZERO_X, EAG_M_PAGE_ZERO_Y,
            EAG_M_RELATIVE}) rd = 3'h1;
        if (md inside {EAG_M_PRE_X_POINTER, EAG_M_POST_Y_POINTER, EAG_M_PAGE_ZERO_POINTER})
            rd = 3'h3;
        if (md inside {EAG_M_ABS_X_POINTER, EAG_M_ABS_POINTER}) rd = 3'h4;
        nx = pc + ((rd == 3'h0) ? 16'h0001 : (rd[0] ? 16'h0002 : 16'h0003));
        ex = 3'h0;
        if (md inside {EAG_M_ABSOLUTE_X, EAG_M_ABSOLUTE_Y})
            ex = {2'h0, (ea[15:8] != base[15:8]) && !st};
        if (md == EAG_M_POST_Y_POINTER)
            ex = {2'h0, (ea[15:8] != m({8'h00, b1 + 8'h01})) && !st};
        if (md == EAG_M_ABS_POINTER) ex = {2'h0, b1 == 8'hFF};
        if (md == EAG_M_RELATIVE && s[1]) ex = (ea[15:8] == nx[15:8]) ? 3'h1 : 3'h2;
        if (s[0] && op inside {8'h69, 8'h7D, 8'hF1}) ex = ex + 3'h1;
        n.lat = 3'h1 + rd + ex;
        n.md = md;
        n.ea = ea;
        n.ea_on = rd != 3'h0 && md != EAG_M_IMMEDIATE;
        n.opd = b1;
        n.opd_on = md == EAG_M_IMMEDIATE;
        n.pcn = (rd == 3'h4 || (md == EAG_M_RELATIVE && s[1])) ? ea : nx;
        n.flg = {op == 8'h6C || op == 8'h7C, md == EAG_M_ACCUM, op == 8'h89};
        @(negedge clk);
        req = '{op, pc, x, y, s[0], s[1]};
        start = 1'b1;
        n.cyc = cyc;
        notes.push_back(n);
        // A second start while busy must be ignored.
        @(negedge clk);
        req.opcode = 8'hEA;
        @(negedge clk);
        start = 1'b0;
        w = 0;
        while (notes.size() != 0 && w < 12) begin
            @(negedge clk);
            w++;
        end
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock generator.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Cycle count and hang guard.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    // Compares each completion with the oldest noted expectation.
    always @(negedge clk) begin
        if (rst_b === 1'b1 && done === 1'b1) begin
            if (notes.size() == 0) begin
                check("spare_done", 16'h0001, 16'h0000);
            end else begin
                mn = notes.pop_front();
                check("latency", 16'(cyc - mn.cyc), {13'h0, mn.lat});
                check("mode", {12'h0, mode}, {12'h0, mn.md});
                if (mn.ea_on) check("eff_addr", eff_addr, mn.ea);
                if (mn.opd_on) check("operand", {8'h00, operand}, {8'h00, mn.opd});
                check("pc_next", pc_next, mn.pcn);
                check("flags", {13'h0, pc_load, acc_target, keep_nv}, {13'h0, mn.flg});
            end
        end
    end

    // Main sequence: memory fill, reset, table sweeps, then pointer edge cases.
    initial begin
        logic [31:0] r;
        rst_b = 1'b0;
        start = 1'b0;
        req = '0;
        for (int i = 0; i < 65536; i++) begin
            r = rnd();
            mem_i.mem[i] = r[7:0];
        end
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        repeat (8) for (int i = 0; i < 22; i++) run(OPS[i], MDS[i], 1'b0);
        run(8'h6C, EAG_M_ABS_POINTER, 1'b1);
        run(8'hB2, EAG_M_PAGE_ZERO_POINTER, 1'b1);
        run(8'hA1, EAG_M_PRE_X_POINTER, 1'b1);
        run(8'hB1, EAG_M_POST_Y_POINTER, 1'b1);
        finish_test();
    end
endmodule // effective_address_generator_bench
